/* File: acq_timing_regs.vh */
// Constants for the acquisition timing and trigger control block
`ifndef ACQ_TIMING_REGS_VH
`define ACQ_TIMING_REGS_VH

// =====================================================================
// Timing modes
`define MODE_ON_DEMAND      2'h0
`define MODE_FINITE         2'h1
`define MODE_CONTINUOUS     2'h2
`define MODE_SINGLE_POINT   2'h3

// =====================================================================
// Trigger source selection
`define TRIG_SRC_NONE       2'h0
`define TRIG_SRC_DIGITAL    2'h1
`define TRIG_SRC_ANALOG     2'h2

// =====================================================================
// Defaults
`define SAMPLE_W            16
`define FIFO_DEPTH          16
`define FIFO_AW             4
`define COUNT_W             32
`define DIV_W               16
`define BLOCK_LEN           8
`define PRE_CNT_RESET       32'h0000_0000

`endif

/* File: acq_sample_fifo.v */
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module acq_sample_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and reset
   input  wire             clk_i,
   input  wire             sys_rst_i,
   // Fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // Drain side
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   // Status
   output wire [AW:0]      level_o
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW:0]      wr_ptr;
   reg  [AW:0]      rd_ptr;
   wire             do_wr;
   wire             do_rd;

   assign level_o     = wr_ptr - rd_ptr;
   assign in_ready_o  = (level_o != DEPTH[AW:0]);
   assign out_valid_o = (level_o != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr[AW-1:0]];
   assign do_wr       = in_valid_i & in_ready_o;
   assign do_rd       = out_valid_o & out_ready_i;

   always @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // acq_sample_fifo

`default_nettype wire

/* File: acq_pin_sync.v */
// Three-stage synchroniser bank for pin inputs with agreement filter
`timescale 1ns/1ps
`default_nettype none

module acq_pin_sync #(
   parameter N = 4
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         sys_rst_i,
   // Pins and filtered levels
   input  wire [N-1:0] pin_i,
   output wire [N-1:0] level_o
);

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_sync
         reg s1;
         reg s2;
         reg s3;
         reg lvl;
         always @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               s1  <= 1'b0;
               s2  <= 1'b0;
               s3  <= 1'b0;
               lvl <= 1'b0;
            end else begin
               s1 <= pin_i[g];
               s2 <= s1;
               s3 <= s2;
               // Change is accepted only once stages two and three agree
               if (s2 == s3) begin
                  lvl <= s2;
               end
            end
         end
         assign level_o[g] = lvl;
      end
   endgenerate

endmodule // acq_pin_sync

`default_nettype wire

/* File: acq_timing_ctrl.v */
// Acquisition timing and trigger control: pacing, modes, triggers, FIFO and DMA blocks
`timescale 1ns/1ps
`default_nettype none
`include "acq_timing_regs.vh"

// Notes on behaviour
// - Hardware-timed conversions start on pacing edges
// - Pacing clock internal divider or external pin
// - Buffered samples via FIFO, DMA in blocks
// - Finite mode stops after programmed count
// - Reference trigger allowed only in finite
// - Continuous mode runs until stop command
// - Full FIFO on new sample flags overflow
// - Single-point mode flags software lateness
// - Start, reference and pause trigger actions
// - Each trigger digital or analog source
// - On-demand mode: one conversion per command
module acq_timing_ctrl #(
   parameter SAMPLE_W = `SAMPLE_W,
   parameter DEPTH    = `FIFO_DEPTH,
   parameter AW       = `FIFO_AW,
   parameter COUNT_W  = `COUNT_W,
   parameter DIV_W    = `DIV_W,
   parameter BLOCK    = `BLOCK_LEN
) (
   // Clock and reset
   input  wire                clk_i,
   input  wire                sys_rst_i,
   // Configuration, held stable while running
   input  wire [1:0]          mode_i,
   input  wire                ext_clk_sel_i,
   input  wire [DIV_W-1:0]    pace_div_i,
   input  wire [COUNT_W-1:0]  sample_count_i,
   input  wire [COUNT_W-1:0]  pretrig_count_i,
   input  wire [1:0]          start_src_i,
   input  wire [1:0]          ref_src_i,
   input  wire [1:0]          pause_src_i,
   // Software commands, one-cycle pulses
   input  wire                arm_i,
   input  wire                stop_i,
   input  wire                convert_i,
   input  wire                sp_read_i,
   input  wire                err_clear_i,
   // External pins
   input  wire                ext_pace_pin_i,
   input  wire                start_dig_pin_i,
   input  wire                ref_dig_pin_i,
   input  wire                pause_dig_pin_i,
   // Analog comparator results, same clock
   input  wire                start_ana_i,
   input  wire                ref_ana_i,
   input  wire                pause_ana_i,
   // Converter
   output reg                 adc_start_o,
   input  wire                adc_done_i,
   input  wire [SAMPLE_W-1:0] adc_data_i,
   // DMA
   output reg                 dma_valid_o,
   output reg [SAMPLE_W-1:0]  dma_data_o,
   output reg                 dma_last_o,
   input  wire                dma_ready_i,
   // Single-point result
   output reg [SAMPLE_W-1:0]  sp_data_o,
   output reg                 sp_valid_o,
   // Status
   output reg                 running_o,
   output reg                 done_o,
   output reg                 overflow_o,
   output reg                 late_o,
   output reg                 config_err_o
);

   // ==================================================================
   // State codes
   localparam ST_IDLE  = 2'h0;
   localparam ST_WAIT  = 2'h1;
   localparam ST_RUN   = 2'h2;
   localparam ST_DRAIN = 2'h3;
   reg  [1:0] state;
   reg  [1:0] next_state;

   function trig_sel;
      input [1:0] src;
      input       dig;
      input       ana;
      begin
         case (src)
            `TRIG_SRC_DIGITAL: trig_sel = dig;
            `TRIG_SRC_ANALOG:  trig_sel = ana;
            default:           trig_sel = 1'b0;
         endcase
      end
   endfunction

   // ==================================================================
   // Pin synchronisers
   wire [3:0] pin_lvl;
   acq_pin_sync #(
      .N (4)
   ) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({pause_dig_pin_i, ref_dig_pin_i, start_dig_pin_i, ext_pace_pin_i}),
      .level_o   (pin_lvl)
   );

   // ==================================================================
   // Trigger selection and edge detection
   wire start_lvl = trig_sel(start_src_i, pin_lvl[1], start_ana_i);
   wire ref_lvl   = trig_sel(ref_src_i, pin_lvl[2], ref_ana_i);
   wire pause_lvl = trig_sel(pause_src_i, pin_lvl[3], pause_ana_i);
   reg  start_q;
   reg  ref_q;
   reg  ext_q;
   wire start_edge = start_lvl & ~start_q;
   wire ref_edge   = ref_lvl & ~ref_q;
   wire ref_used   = (ref_src_i != `TRIG_SRC_NONE);
   wire hw_mode    = (mode_i != `MODE_ON_DEMAND);

   // ==================================================================
   // Pacing clock
   reg  [DIV_W-1:0] div_cnt;
   wire             int_tick = (div_cnt == {DIV_W{1'b0}});
   wire             ext_tick = pin_lvl[0] & ~ext_q;
   wire             pace_raw = ext_clk_sel_i ? ext_tick : int_tick;

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_cnt <= {DIV_W{1'b0}};
         start_q <= 1'b0;
         ref_q   <= 1'b0;
         ext_q   <= 1'b0;
      end else begin
         start_q <= start_lvl;
         ref_q   <= ref_lvl;
         ext_q   <= pin_lvl[0];
         if (int_tick) begin
            div_cnt <= pace_div_i;
         end else begin
            div_cnt <= div_cnt - {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==================================================================
   // FIFO
   wire                fifo_in_ready;
   wire                fifo_out_valid;
   wire [SAMPLE_W-1:0] fifo_out_data;
   wire [AW:0]         fifo_level;
   reg                 blk_active;
   reg  [7:0]          blk_cnt;
   wire                buffered = (mode_i == `MODE_FINITE) || (mode_i == `MODE_CONTINUOUS);
   wire                fifo_wr  = adc_done_i & buffered & (state != ST_IDLE);
   wire                fifo_rd  = fifo_out_valid & (~dma_valid_o | dma_ready_i) & blk_active;

   acq_sample_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .in_valid_i  (fifo_wr),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (adc_data_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_rd),
      .out_data_o  (fifo_out_data),
      .level_o     (fifo_level)
   );

   // ==================================================================
   // Acquisition state machine
   reg  [COUNT_W-1:0] acq_cnt;
   reg  [COUNT_W-1:0] post_cnt;
   reg                ref_seen;
   reg                busy;
   wire               paused  = pause_lvl & (state == ST_RUN);
   // Stop beats a pacing edge so no conversion starts as the run ends
   wire               pace    = pace_raw & hw_mode & (state == ST_RUN) & ~paused & ~stop_i;
   wire [COUNT_W-1:0] target  = ref_used ? post_cnt : sample_count_i;
   wire               fin_hit = (mode_i == `MODE_FINITE) && (!ref_used || ref_seen) &&
                                (acq_cnt >= target);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // Reference trigger with a non-finite mode is refused
            if (arm_i && hw_mode && !(ref_used && mode_i != `MODE_FINITE)) begin
               next_state = (start_src_i == `TRIG_SRC_NONE) ? ST_RUN : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (stop_i) begin
               next_state = ST_IDLE;
            end else if (start_edge) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_i || (fin_hit && !busy)) begin
               next_state = buffered ? ST_DRAIN : ST_IDLE;
            end
         end
         ST_DRAIN: begin
            if (!fifo_out_valid && !dma_valid_o && !busy) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state        <= ST_IDLE;
         acq_cnt      <= `PRE_CNT_RESET;
         post_cnt     <= `PRE_CNT_RESET;
         ref_seen     <= 1'b0;
         busy         <= 1'b0;
         adc_start_o  <= 1'b0;
         running_o    <= 1'b0;
         done_o       <= 1'b0;
         config_err_o <= 1'b0;
      end else begin
         state       <= next_state;
         running_o   <= (next_state == ST_RUN) || (next_state == ST_WAIT);
         done_o      <= (state == ST_DRAIN || state == ST_RUN) && next_state == ST_IDLE;
         adc_start_o <= 1'b0;
         if (arm_i && state == ST_IDLE) begin
            config_err_o <= ref_used && mode_i != `MODE_FINITE;
            acq_cnt      <= `PRE_CNT_RESET;
            ref_seen     <= 1'b0;
         end
         if (adc_done_i) begin
            busy <= 1'b0;
         end
         if (state == ST_IDLE && mode_i == `MODE_ON_DEMAND && convert_i && !busy) begin
            adc_start_o <= 1'b1;
            busy        <= 1'b1;
         end
         // Pausing leaves acq_cnt untouched so resume continues the count
         if (pace && !fin_hit && !busy) begin
            adc_start_o <= 1'b1;
            busy        <= 1'b1;
            acq_cnt     <= acq_cnt + {{(COUNT_W-1){1'b0}}, 1'b1};
         end
         if (state == ST_RUN && ref_used && !ref_seen && ref_edge && acq_cnt >= pretrig_count_i) begin
            ref_seen <= 1'b1;
            post_cnt <= acq_cnt + (sample_count_i - pretrig_count_i);
         end
      end
   end

   // ==================================================================
   // DMA block transfer and overflow
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dma_valid_o <= 1'b0;
         dma_data_o  <= {SAMPLE_W{1'b0}};
         dma_last_o  <= 1'b0;
         blk_active  <= 1'b0;
         blk_cnt     <= 8'h00;
         overflow_o  <= 1'b0;
      end else begin
         // A block opens once enough samples wait, or to flush at the end
         if (!blk_active && (fifo_level >= BLOCK[AW:0] || (state == ST_DRAIN && fifo_out_valid))) begin
            blk_active <= 1'b1;
            blk_cnt    <= 8'h00;
         end
         if (dma_valid_o && dma_ready_i) begin
            dma_valid_o <= 1'b0;
         end
         if (fifo_rd) begin
            dma_valid_o <= 1'b1;
            dma_data_o  <= fifo_out_data;
            blk_cnt     <= blk_cnt + 8'h01;
            dma_last_o  <= (blk_cnt == BLOCK[7:0] - 8'h01) || (fifo_level == {{AW{1'b0}}, 1'b1});
            if (blk_cnt == BLOCK[7:0] - 8'h01 || fifo_level == {{AW{1'b0}}, 1'b1}) begin
               blk_active <= 1'b0;
            end
         end
         // Set wins over clear
         if (fifo_wr && !fifo_in_ready) begin
            overflow_o <= 1'b1;
         end else if (err_clear_i) begin
            overflow_o <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Single-point result and lateness
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sp_data_o  <= {SAMPLE_W{1'b0}};
         sp_valid_o <= 1'b0;
         late_o     <= 1'b0;
      end else begin
         if (adc_done_i && !buffered) begin
            sp_data_o  <= adc_data_i;
            sp_valid_o <= 1'b1;
         end else if (sp_read_i) begin
            sp_valid_o <= 1'b0;
         end
         // A new point landing on an unread one means software fell behind
         if (adc_done_i && mode_i == `MODE_SINGLE_POINT && sp_valid_o && !sp_read_i) begin
            late_o <= 1'b1;
         end else if (err_clear_i) begin
            late_o <= 1'b0;
         end
      end
   end

endmodule // acq_timing_ctrl

`default_nettype wire

/* File: acq_timing_ctrl_asserts.sv */
// Concurrent checks on the ports of the acquisition timing control block
`timescale 1ns/1ps
`default_nettype none

module acq_timing_ctrl_chk (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   // Watched inputs
   input wire logic [1:0]  mode_i,
   input wire logic [1:0]  ref_src_i,
   input wire logic [1:0]  pause_src_i,
   input wire logic        arm_i,
   input wire logic        convert_i,
   input wire logic        sp_read_i,
   input wire logic        err_clear_i,
   input wire logic        pause_ana_i,
   input wire logic        adc_done_i,
   input wire logic        dma_ready_i,
   // Watched outputs
   input wire logic        adc_start_o,
   input wire logic        dma_valid_o,
   input wire logic [15:0] dma_data_o,
   input wire logic        dma_last_o,
   input wire logic        sp_valid_o,
   input wire logic        running_o,
   input wire logic        done_o,
   input wire logic        overflow_o,
   input wire logic        late_o,
   input wire logic        config_err_o
);
   // ==========================================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
      else $error("converter start longer than one cycle");
   a_demand_cause: assert property (mode_i == 2'h0 && adc_start_o |-> $past(convert_i))
      else $error("on-demand conversion without command");
   a_ref_refused: assert property (arm_i && !running_o && ref_src_i != 2'h0 && mode_i == 2'h2
      |=> config_err_o && !running_o) else $error("reference trigger accepted in continuous mode");
   a_arm_runs: assert property (arm_i && !running_o && ref_src_i == 2'h0 && mode_i == 2'h1 |=> running_o)
      else $error("finite arm did not start");
   a_hw_running: assert property (adc_start_o && mode_i != 2'h0 |-> running_o)
      else $error("timed conversion while stopped");
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   a_ovf_sticky: assert property (overflow_o && !err_clear_i |=> overflow_o)
      else $error("overflow flag lost without clear");
   a_dma_hold: assert property (dma_valid_o && !dma_ready_i
      |=> dma_valid_o && $stable(dma_data_o) && $stable(dma_last_o)) else $error("transfer changed while stalled");
   a_pause_blocks: assert property ((pause_src_i == 2'h2 && pause_ana_i) [*3] |-> !adc_start_o)
      else $error("conversion during pause");
   a_late_flag: assert property (mode_i == 2'h3 && adc_done_i && sp_valid_o && !sp_read_i |=> late_o)
      else $error("lateness not flagged");
endmodule // acq_timing_ctrl_chk

`default_nettype wire

/* File: acq_far_model.sv */
// Converter and DMA host memory model at the far side of the block
`timescale 1ns/1ps
`default_nettype none

module acq_far_model (
   // Clock, reset and bench controls
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        stall_i,
   input wire logic        slow_i,
   input wire logic        clear_i,
   // Converter
   input wire logic        adc_start_i,
   output logic            adc_done_o,
   output logic [15:0]     adc_data_o,
   // DMA
   input wire logic        dma_valid_i,
   input wire logic [15:0] dma_data_i,
   input wire logic        dma_last_i,
   output logic            dma_ready_o,
   // Counts seen
   output int              words_o,
   output int              lasts_o,
   output int              starts_o,
   output int              order_err_o
);
   logic [1:0]  busy;
   logic [15:0] next_val;
   logic        tick;
   logic [15:0] sent[$];

   // ==========================================================
   // Host accepts blocks, slowly when asked, never while stalled
   assign dma_ready_o = !stall_i && (!slow_i || tick);

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy <= 2'h0; next_val <= 16'h0001; adc_done_o <= 1'b0; adc_data_o <= 16'hFFFF; tick <= 1'b0;
         words_o <= 0; lasts_o <= 0; starts_o <= 0; order_err_o <= 0;
      end else begin
         tick <= ~tick;
         busy <= {busy[0], adc_start_i};
         adc_done_o <= busy[1];
         // Data only valid with done; otherwise the lines wander
         if (busy[1]) begin
            adc_data_o <= next_val;
            next_val <= next_val + 16'h0001;
            sent.push_back(next_val);
         end else begin
            adc_data_o <= ~adc_data_o;
         end
         if (clear_i) begin
            words_o <= 0; lasts_o <= 0; starts_o <= 0; order_err_o <= 0;
            sent.delete();
         end else begin
            if (adc_start_i) starts_o <= starts_o + 1;
            if (dma_valid_i && dma_ready_o) begin
               words_o <= words_o + 1;
               if (dma_last_i) lasts_o <= lasts_o + 1;
               if (sent.size() == 0 || sent.pop_front() !== dma_data_i) order_err_o <= order_err_o + 1;
            end
         end
      end
   end
endmodule // acq_far_model

`default_nettype wire

/* File: tb_acq_timing_ctrl.sv */
// Self-checking bench for the acquisition timing control block
`timescale 1ns/1ps
`default_nettype none

module tb_acq_timing_ctrl;
   logic        clk_i = 0, sys_rst_i = 1;
   logic [1:0]  mode = 0, ref_src = 0, pause_src = 0, start_src = 0;
   logic        ext_sel = 0, ext_pin = 0, start_pin = 0, pause_ana = 0, ref_ana = 0, stall = 0, slow = 0;
   logic [15:0] div = 0;
   logic [15:0] point = 0;
   logic [31:0] cnt = 1;
   logic [5:0]  cmd = 0;
   wire         adc_start, adc_done, dma_valid, dma_last, dma_ready, sp_valid, running, done, ovf, late, cerr;
   wire  [15:0] adc_data, dma_data, sp_data;
   int          words, lasts, starts, order_err, held = 0, num_errors = 0, n_checks = 0;
   typedef struct packed {logic ext; logic [15:0] div; logic [31:0] cnt;} row_t;
   // Last row paces from the external pin
   row_t rows[5] = '{'{1'b0, 16'h0000, 32'h1}, '{1'b0, 16'h0000, 32'h8}, '{1'b0, 16'h0003, 32'h9},
                     '{1'b0, 16'h0001, 32'h11}, '{1'b1, 16'h0000, 32'h4}};

   always #25 clk_i = ~clk_i;
   always #600 ext_pin = ~ext_pin;

   acq_timing_ctrl dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode), .ext_clk_sel_i(ext_sel),
      .pace_div_i(div), .sample_count_i(cnt), .pretrig_count_i(32'h0), .start_src_i(start_src),
      .ref_src_i(ref_src), .pause_src_i(pause_src), .arm_i(cmd[0]), .stop_i(cmd[1]), .convert_i(cmd[2]),
      .sp_read_i(cmd[3]), .err_clear_i(cmd[4]), .ext_pace_pin_i(ext_pin), .start_dig_pin_i(start_pin),
      .ref_dig_pin_i(1'b0), .pause_dig_pin_i(1'b0), .start_ana_i(1'b0), .ref_ana_i(ref_ana),
      .pause_ana_i(pause_ana), .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_data_i(adc_data),
      .dma_valid_o(dma_valid), .dma_data_o(dma_data), .dma_last_o(dma_last), .dma_ready_i(dma_ready),
      .sp_data_o(sp_data), .sp_valid_o(sp_valid), .running_o(running), .done_o(done), .overflow_o(ovf),
      .late_o(late), .config_err_o(cerr));

   acq_far_model far_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall), .slow_i(slow), .clear_i(cmd[5]),
      .adc_start_i(adc_start), .adc_done_o(adc_done), .adc_data_o(adc_data), .dma_valid_i(dma_valid),
      .dma_data_i(dma_data), .dma_last_i(dma_last), .dma_ready_o(dma_ready), .words_o(words),
      .lasts_o(lasts), .starts_o(starts), .order_err_o(order_err));

   // ==========================================================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task pulse(input logic [5:0] c);
      @(negedge clk_i) cmd = c;
      @(negedge clk_i) cmd = 6'h00;
   endtask
   task idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task wait_done;
      int i;
      for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk_i);
      chk({31'h0, done}, 32'h1, "completion pulse");
   endtask
   task results;
      $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      idle(1);
      chk({running, done, ovf, late, cerr, adc_start, dma_valid, sp_valid}, 32'h0, "outputs in reset");
      idle(1);
      sys_rst_i = 0;
      $display("reset test done");
      mode = 2'h1;
      foreach (rows[i]) begin
         {ext_sel, div, cnt} = rows[i];
         slow = i[0];
         pulse(6'h21);
         wait_done;
         idle(3);
         chk(starts, cnt, "conversions");
         chk(words, cnt, "words moved");
         chk(lasts, (cnt + 7) / 8, "blocks moved");
         chk(order_err, 0, "sample order");
         $display("finite row %0d done", i);
      end
      ext_sel = 0; slow = 0; pause_src = 2'h2; pause_ana = 1; div = 16'h0003; cnt = 32'h6;
      pulse(6'h21);
      idle(40);
      chk(starts, 0, "conversions while paused");
      pause_ana = 0;
      wait_done;
      idle(3);
      chk(words, 6, "count kept over pause");
      pause_src = 2'h0;
      $display("pause test done");
      mode = 2'h0;
      pulse(6'h20);
      pulse(6'h04);
      idle(6);
      point = sp_data;
      repeat (2) begin
         pulse(6'h04);
         idle(6);
         point++;
         chk(sp_data, point, "on-demand point");
      end
      chk(starts, 3, "on-demand conversions");
      $display("on-demand test done");
      mode = 2'h3; div = 16'h0009;
      pulse(6'h21);
      idle(30);
      chk({31'h0, sp_valid}, 32'h1, "point held");
      chk({31'h0, late}, 32'h1, "lateness flag");
      pulse(6'h02);
      idle(10);
      pulse(6'h08);
      chk({31'h0, sp_valid}, 32'h0, "point taken by read");
      $display("single point test done");
      mode = 2'h2; div = 16'h0000; start_src = 2'h1; stall = 1;
      pulse(6'h21);
      idle(30);
      chk(starts, 0, "waiting for start trigger");
      start_pin = 1;
      idle(150);
      chk({31'h0, ovf}, 32'h1, "overflow flag");
      chk({31'h0, running}, 32'h1, "continuous still running");
      pulse(6'h02);
      stall = 0;
      wait_done;
      pulse(6'h10);
      idle(2);
      chk({31'h0, ovf}, 32'h0, "overflow cleared");
      start_pin = 0; start_src = 2'h0;
      $display("continuous test done");
      ref_src = 2'h1;
      pulse(6'h01);
      idle(2);
      chk({31'h0, cerr}, 32'h1, "refused setup");
      chk({31'h0, running}, 32'h0, "idle after refusal");
      $display("config test done");
      mode = 2'h1; ref_src = 2'h2; pause_src = 2'h2; cnt = 32'h6; div = 16'h0003;
      pulse(6'h21);
      idle(20);
      pause_ana = 1;
      idle(10);
      held = starts;
      ref_ana = 1;
      idle(20);
      chk(starts, held, "held while paused");
      chk({31'h0, cerr}, 32'h0, "reference accepted in finite");
      pause_ana = 0;
      wait_done;
      idle(3);
      chk(starts, held + 6, "points after reference");
      chk(words, starts, "reference run moved");
      chk(order_err, 0, "reference run order");
      $display("reference test done");
      results;
   end

   initial begin
      #(50 * 20000);
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      results;
   end
endmodule // tb_acq_timing_ctrl

bind acq_timing_ctrl acq_timing_ctrl_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode_i),
   .ref_src_i(ref_src_i), .pause_src_i(pause_src_i), .arm_i(arm_i), .convert_i(convert_i),
   .sp_read_i(sp_read_i), .err_clear_i(err_clear_i), .pause_ana_i(pause_ana_i), .adc_done_i(adc_done_i),
   .dma_ready_i(dma_ready_i), .adc_start_o(adc_start_o), .dma_valid_o(dma_valid_o), .dma_data_o(dma_data_o),
   .dma_last_o(dma_last_o), .sp_valid_o(sp_valid_o), .running_o(running_o), .done_o(done_o),
   .overflow_o(overflow_o), .late_o(late_o), .config_err_o(config_err_o));

`default_nettype wire
